// ==== cfw_regs.svh ====
`ifndef CFW_REGS_SVH
`define CFW_REGS_SVH
// ==========================================
// register byte offsets
`define CFW_CTRL 8'h00
`define CFW_STATUS 8'h04
`define CFW_ACL 8'h08
`define CFW_ACH 8'h0c
`define CFW_MQL 8'h10
`define CFW_MQH 8'h14
`define CFW_PC 8'h18
`define CFW_SRL 8'h1c
`define CFW_SRH 8'h20
`define CFW_IR 8'h24
`define CFW_CTRL_START 0
`define CFW_CTRL_STOP 1
// ==========================================
// opcodes as {sign, nine octal bits}
`define CFW_OP_STO 10'h181
`define CFW_OP_SLW 10'h182
`define CFW_OP_STQ 10'h380
`define CFW_OP_STZ 10'h180
`define CFW_OP_STP 10'h198
`define CFW_OP_STD 10'h192
`define CFW_OP_STT 10'h195
`define CFW_OP_STA 10'h191
`define CFW_OP_SLQ 10'h390
`define CFW_OP_STL 10'h395
`define CFW_OP_LDQ 10'h170
`define CFW_OP_XCA 10'h059
`define CFW_OP_XCL 10'h258
`define CFW_L_LOW_MAX 9'h07f
`define CFW_L_HIGH_MIN 9'h1c0
`define CFW_PRIM_SHIFT 6'h3e
// ==========================================
// ring slots, one clock each
`define CFW_SLOT_REQ 4'h0
`define CFW_SLOT_GATE 4'h6
`define CFW_SLOT_LOAD 4'h7
`define CFW_SLOT_IR 4'h8
`define CFW_SLOT_DEC 4'h9
`define CFW_SLOT_EXE 4'ha
`define CFW_SLOT_LAST 4'hb
`endif

// ==== cfw_pkg.sv ====
package cfw_pkg;
	typedef logic [0:35] cfw_word_t;
	typedef struct packed {
		logic s;
		logic q;
		logic p;
		logic [1:35] m;
	} cfw_acc_t;
	typedef struct packed {
		logic prefix;
		logic decr;
		logic tag;
		logic addr;
		logic ctl;
	} cfw_strobe_t;
	typedef enum logic [3:0] {
		CFW_IDLE = 4'h1,
		CFW_I = 4'h2,
		CFW_E = 4'h4,
		CFW_L = 4'h8
	} cfw_cyc_t;
endpackage : cfw_pkg

// ==== cfw_core.sv ====
// Our own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`include "cfw_regs.svh"
// What this block does
// - store word gated out only in E
// - cpu address to memory unless channel cycle or look-ahead
// - two 36-bit memory halves ORed together
// - word read each I, optionally in E
// - channel gets bus in B or load E
// - bus address field switched only in look-ahead
// - gate bus at I6, load buffer at I7
// - I8 loads opcode, prefix or normal form
// - non-store E: gate E6, load buffer E7
// - done flag at end and start, fetch next
// - low or high opcodes take L, else E
// - single-cycle ops return straight to I; with indirect bits set they take E, then L
// - I bumps counter, address to register/shifter
// - indirect bits insert one address-fetch E
// - full and logical word store, all strobes
// - mq word store; zero store writes zeros
// - prefix store: P,1,2 with prefix strobe
// - decrement, tag, address field stores
// - mq left half store, bits S-17
// - return location store into address field
// - load mq through word buffer
// - swap acc and mq, clear Q,P
// - logical swap, clear acc S,Q
module cfw_core
	import cfw_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [31:0] i_wb_dat,
	input wire logic [3:0] i_wb_sel,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	input wire logic [0:71] i_mem_rdata,
	output logic o_mem_rd,
	output logic o_mem_wr,
	output logic [14:0] o_mem_addr,
	output cfw_word_t o_mem_wdata,
	output cfw_strobe_t o_mem_strobe,
	input wire logic i_chan_cycle,
	input wire logic [14:0] i_chan_addr,
	input wire logic i_chan_load_op,
	input wire logic i_lookahead,
	output cfw_word_t o_chan_bus
);
	// ==========================================
	// state
	cfw_cyc_t cyc;
	cfw_cyc_t nxt;
	logic [3:0] slot;
	logic run;
	logic op_done;
	logic deref;
	logic pfx;
	cfw_acc_t ac;
	cfw_word_t mq;
	cfw_word_t sr;
	cfw_word_t cpu_bus;
	logic [0:9] ir;
	logic [14:0] pc;
	logic [14:0] ar;
	logic [7:0] shift_cnt;
	logic [0:71] mem_sync1;
	logic [0:71] mem_sync2;
	// ==========================================
	// input sync; read data must settle by slot 4
	always_ff @(posedge i_clk) begin
		mem_sync1 <= i_mem_rdata;
		mem_sync2 <= mem_sync1;
	end
	wire cfw_word_t bus_or = mem_sync2[0:35] | mem_sync2[36:71];
	// ==========================================
	// decode
	wire [9:0] op = ir;
	wire is_sto = op == `CFW_OP_STO;
	wire is_slw = op == `CFW_OP_SLW;
	wire is_stq = op == `CFW_OP_STQ;
	wire is_stz = op == `CFW_OP_STZ;
	wire is_stp = op == `CFW_OP_STP;
	wire is_std = op == `CFW_OP_STD;
	wire is_stt = op == `CFW_OP_STT;
	wire is_sta = op == `CFW_OP_STA;
	wire is_slq = op == `CFW_OP_SLQ;
	wire is_stl = op == `CFW_OP_STL;
	wire is_ldq = op == `CFW_OP_LDQ;
	wire is_xca = op == `CFW_OP_XCA;
	wire is_xcl = op == `CFW_OP_XCL;
	wire full_st = is_sto | is_slw | is_stq | is_stz;
	wire st_op = full_st | is_stp | is_std | is_stt | is_sta | is_slq | is_stl;
	wire single = is_xca | is_xcl;
	wire goes_l = (ir[1:9] <= `CFW_L_LOW_MAX) || (ir[1:9] >= `CFW_L_HIGH_MIN);
	wire prim_shift = ir[1:6] == `CFW_PRIM_SHIFT;
	wire indir = !pfx && sr[12] && sr[13];
	wire in_i = cyc == CFW_I;
	wire in_e = cyc == CFW_E;
	wire at_last = slot == `CFW_SLOT_LAST;
	// store source into the word buffer
	wire cfw_word_t acc_word = {ac.s, ac.m};
	wire cfw_word_t accp_word = {ac.p, ac.m};
	wire cfw_word_t st_src = is_slw || is_stp ? accp_word :
		is_stq || is_slq ? mq :
		is_stl ? {21'h0, pc} : acc_word;
	wire cfw_strobe_t st_strb = '{prefix: full_st | is_stp | is_slq,
		decr: full_st | is_std | is_slq,
		tag: full_st | is_stt,
		addr: full_st | is_sta | is_stl,
		ctl: 1'b1};
	wire ld_st = slot == `CFW_SLOT_EXE && nxt == CFW_E && st_op && !(in_i && deref);
	wire store_e = in_e && st_op && !deref;
	// ==========================================
	// wishbone slave, one wait state
	wire wb_req = i_wb_cyc && i_wb_stb;
	wire wb_wr = wb_req && i_wb_we && o_wb_ack;
	wire idle = cyc == CFW_IDLE;
	wire [31:0] sel_mask = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}}, {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
	logic [31:0] rd_val;
	always_comb begin
		unique case (i_wb_adr)
		`CFW_STATUS: rd_val = {24'h0, pfx, deref, op_done, cyc, run};
		`CFW_ACL: rd_val = ac.m[4:35];
		`CFW_ACH: rd_val = {26'h0, ac.q, ac.p, ac.s, ac.m[1:3]};
		`CFW_MQL: rd_val = mq[4:35];
		`CFW_MQH: rd_val = {28'h0, mq[0:3]};
		`CFW_PC: rd_val = {17'h0, pc};
		`CFW_SRL: rd_val = sr[4:35];
		`CFW_SRH: rd_val = {28'h0, sr[0:3]};
		`CFW_IR: rd_val = {22'h0, ir};
		default: rd_val = 32'h0;
		endcase
	end
	wire [31:0] wr_val = (rd_val & ~sel_mask) | (i_wb_dat & sel_mask);
	wire wr_ctl = wb_wr && i_wb_adr == `CFW_CTRL;
	wire do_start = wr_ctl && i_wb_sel[0] && i_wb_dat[`CFW_CTRL_START] && idle;
	wire do_stop = wr_ctl && i_wb_sel[0] && i_wb_dat[`CFW_CTRL_STOP];
	wire wr_reg = wb_wr && idle;
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_wb_ack <= 1'b0;
			o_wb_dat <= 32'h0;
		end else begin
			o_wb_ack <= wb_req && !o_wb_ack;
			o_wb_dat <= rd_val;
		end
	end
	// ==========================================
	// cycle sequencer
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cyc <= CFW_IDLE;
			nxt <= CFW_I;
			slot <= 4'h0;
			run <= 1'b0;
			op_done <= 1'b0;
			deref <= 1'b0;
		end else begin
			if (do_start) begin
				run <= 1'b1;
				op_done <= 1'b1;
			end else if (do_stop) begin
				run <= 1'b0;
			end
			if (idle) begin
				slot <= 4'h0;
				if (run && op_done) begin
					cyc <= CFW_I;
				end
			end else begin
				slot <= at_last ? 4'h0 : slot + 4'h1;
			end
			if (in_i && slot == 4'h1) begin
				op_done <= 1'b0;
			end
			if (slot == `CFW_SLOT_DEC) begin
				unique case (cyc)
				CFW_I: begin
					if (indir) begin
						deref <= 1'b1;
						nxt <= CFW_E;
					end else if (single) begin
						op_done <= 1'b1;
						nxt <= CFW_I;
					end else begin
						nxt <= goes_l ? CFW_L : CFW_E;
					end
				end
				CFW_E: begin
					if (deref) begin
						nxt <= goes_l ? CFW_L : CFW_E;
					end else begin
						op_done <= 1'b1;
						nxt <= CFW_I;
					end
				end
				CFW_L: begin
					op_done <= 1'b1;
					nxt <= CFW_I;
				end
				default: ;
				endcase
			end
			if (!idle && at_last) begin
				if (in_e) begin
					deref <= 1'b0;
				end
				if (op_done && !run) begin
					cyc <= CFW_IDLE;
				end else if (op_done) begin
					cyc <= CFW_I;
				end else begin
					cyc <= nxt;
				end
			end
		end
	end
	// ==========================================
	// datapath
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			ac <= '0;
			mq <= '0;
			sr <= '0;
			ir <= '0;
			pfx <= 1'b0;
			pc <= 15'h0;
			ar <= 15'h0;
			shift_cnt <= 8'h0;
			cpu_bus <= '0;
		end else begin
			if (wr_reg) begin
				unique case (i_wb_adr)
				`CFW_ACL: ac.m[4:35] <= wr_val;
				`CFW_ACH: {ac.q, ac.p, ac.s, ac.m[1:3]} <= wr_val[5:0];
				`CFW_MQL: mq[4:35] <= wr_val;
				`CFW_MQH: mq[0:3] <= wr_val[3:0];
				`CFW_PC: pc <= wr_val[14:0];
				default: ;
				endcase
			end
			if ((in_i || (in_e && !st_op) || (in_e && deref)) && slot == `CFW_SLOT_GATE) begin
				cpu_bus <= bus_or;
			end
			if ((in_i || (in_e && (!st_op || deref))) && slot == `CFW_SLOT_LOAD) begin
				sr <= cpu_bus;
			end
			if (in_i && slot == `CFW_SLOT_IR) begin
				pfx <= cpu_bus[1] | cpu_bus[2];
				if (cpu_bus[1] | cpu_bus[2]) begin
					ir <= {cpu_bus[0], 7'h0, cpu_bus[1:2]};
				end else begin
					ir <= {cpu_bus[0], cpu_bus[3:11]};
				end
			end
			if (in_e && deref && slot == `CFW_SLOT_IR) begin
				ar <= cpu_bus[21:35];
			end
			if (in_e && !deref && is_ldq && slot == `CFW_SLOT_IR) begin
				mq <= sr;
			end
			if (in_i && slot == `CFW_SLOT_DEC) begin
				pc <= pc + 15'h1;
				if (prim_shift) begin
					shift_cnt <= sr[28:35];
				end else begin
					ar <= sr[21:35];
				end
			end
			// exchanges finish inside the I cycle, buffer holds old mq
			if (in_i && slot == `CFW_SLOT_EXE && is_xca) begin
				sr <= mq;
				ac <= '{s: mq[0], q: 1'b0, p: 1'b0, m: mq[1:35]};
				mq <= acc_word;
			end else if (in_i && slot == `CFW_SLOT_EXE && is_xcl) begin
				sr <= mq;
				ac <= '{s: 1'b0, q: 1'b0, p: mq[0], m: mq[1:35]};
				mq <= accp_word;
			end else if (ld_st) begin
				sr <= st_src;
			end
		end
	end
	// ==========================================
	// memory and channel side, all registered
	wire [14:0] cpu_addr = in_i ? pc : ar;
	wire [14:0] next_addr = i_chan_cycle ? i_chan_addr :
		i_lookahead ? bus_or[21:35] : cpu_addr;
	wire chan_open = i_chan_cycle || (in_e && i_chan_load_op);
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_mem_rd <= 1'b0;
			o_mem_wr <= 1'b0;
			o_mem_addr <= 15'h0;
			o_mem_wdata <= '0;
			o_mem_strobe <= '0;
			o_chan_bus <= '0;
		end else begin
			o_mem_addr <= next_addr;
			o_mem_rd <= slot == `CFW_SLOT_REQ && (in_i || (in_e && !store_e));
			o_mem_wr <= slot == `CFW_SLOT_REQ && store_e;
			o_mem_wdata <= store_e && !is_stz ? sr : '0;
			o_mem_strobe <= store_e ? st_strb : '0;
			o_chan_bus <= chan_open ? bus_or : '0;
		end
	end
	// ==========================================
	// checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	chk_store_gate: assert property (o_mem_wdata != '0 |-> $past(cyc) == CFW_E)
		else $error("store data outside E cycle");
	chk_cpu_addr: assert property (!i_chan_cycle && !i_lookahead && in_i |=> o_mem_addr == $past(pc))
		else $error("fetch address not from counter");
	chk_chan_gate: assert property (o_chan_bus != '0 |-> $past(chan_open))
		else $error("channel bus open outside its cycles");
	chk_fetch_read: assert property (in_i && slot == 4'h0 |=> o_mem_rd ##1 !o_mem_rd)
		else $error("no single read pulse in I cycle");
	chk_ir_prefix: assert property (in_i && slot == 4'h8 && cpu_bus[1] |=> ir[1:7] == 7'h0 && ir[8])
		else $error("prefix form opcode misloaded");
	chk_e_load: assert property (in_e && !st_op && slot == 4'h6 |=> ##1 sr == $past(bus_or, 2))
		else $error("E word not in buffer at slot 7");
	chk_pc_step: assert property (in_i && slot == 4'h9 |=> pc == 15'($past(pc) + 15'h1))
		else $error("counter not advanced");
	chk_single_ret: assert property (in_i && at_last && single && run |=> in_i && slot == 4'h0)
		else $error("single cycle op left I time");
	chk_deref_end: assert property (in_e && deref && at_last |=> !deref)
		else $error("indirect flag stuck after E");
	chk_zero_store: assert property (store_e && is_stz && slot == 4'h3 |-> o_mem_wdata == '0 && o_mem_strobe.ctl)
		else $error("zero store sent data");
	// ==========================================
	// memory link checks
	// the write pulse must stay one clock, storage latches on every edge it sees
	chk_wr_pulse: assert property (o_mem_wr |=> !o_mem_wr)
		else $error("write pulse longer than one clock");
	chk_chan_addr: assert property (i_chan_cycle |=> o_mem_addr == $past(i_chan_addr))
		else $error("channel address not switched through");
	chk_la_addr: assert property (i_lookahead && !i_chan_cycle |=> o_mem_addr == $past(bus_or[21:35]))
		else $error("look-ahead address not from bus");
	// strobes lag store_e by one clock, so slot 0 of the cycle is skipped
	chk_strobe_hold: assert property (store_e && slot != 4'h0 |-> o_mem_strobe == st_strb)
		else $error("field strobes not held through store");
	// ==========================================
	// fetch and decode checks
	chk_sr_fetch: assert property (in_i && slot == 4'h7 |=> sr == $past(cpu_bus))
		else $error("fetched word not in buffer");
	chk_ir_normal: assert property (in_i && slot == 4'h8 && !cpu_bus[1] && !cpu_bus[2]
		|=> ir == {$past(cpu_bus[0]), $past(cpu_bus[3:11])})
		else $error("normal form opcode misloaded");
	chk_deref_addr: assert property (in_e && deref && slot == 4'h8 |=> ar == $past(cpu_bus[21:35]))
		else $error("indirect address not substituted");
	// ==========================================
	// transfer instruction checks
	chk_slw_sign: assert property (ld_st && is_slw |=> sr[0] == $past(ac.p))
		else $error("logical store sign not from P");
	chk_stl_src: assert property (ld_st && is_stl |=> sr == {21'h0, $past(pc)})
		else $error("return location not in buffer");
	chk_ldq_copy: assert property (in_e && !deref && is_ldq && slot == 4'h8 |=> mq == $past(sr))
		else $error("quotient register not loaded from buffer");
	chk_xca_clear: assert property (in_i && slot == 4'ha && is_xca |=> !ac.q && !ac.p)
		else $error("exchange left Q or P set");
	// ==========================================
	// coverage of the main scenarios
	cov_load_mq: cover property (in_e && is_ldq && slot == 4'h8);
	cov_fetch: cover property (in_i && o_mem_rd);
	cov_store: cover property (in_e && st_op && o_mem_wr);
	cov_indirect: cover property (in_e && deref && at_last);
	cov_exchange: cover property (in_i && slot == 4'ha && single);
endmodule : cfw_core

// ==== cfw_mem_model.sv ====
`timescale 1ns/1ps
// ==========================================
// storage behind the multiplexor buses
module cfw_mem_model
	import cfw_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rd,
	input wire logic i_wr,
	input wire logic [14:0] i_addr,
	input wire cfw_word_t i_wdata,
	input wire cfw_strobe_t i_strobe,
	output logic [0:71] o_rdata
);
	cfw_word_t cells [0:31];
	cfw_word_t last = '0;
	logic hi = 1'b0;
	int hold = 0;
	// word stands 8 clocks, then inverted so a late capture shows up
	always @(posedge i_clk) begin
		if (i_rd) begin
			last <= cells[i_addr[4:0]];
			hi <= i_addr[0];
			hold <= 8;
		end else if (hold > 0) begin
			hold <= hold - 1;
		end
		if (i_wr && i_strobe.ctl) begin
			if (i_strobe.prefix) cells[i_addr[4:0]][0:2] <= i_wdata[0:2];
			if (i_strobe.decr) cells[i_addr[4:0]][3:17] <= i_wdata[3:17];
			if (i_strobe.tag) cells[i_addr[4:0]][18:20] <= i_wdata[18:20];
			if (i_strobe.addr) cells[i_addr[4:0]][21:35] <= i_wdata[21:35];
		end
	end
	assign o_rdata = (hold == 0) ? {~last, ~last} : (hi ? {36'h0, last} : {last, 36'h0});
endmodule : cfw_mem_model

// ==== cpu_fetch_and_word_transfer_bench.sv ====
`timescale 1ns/1ps
`include "cfw_regs.svh"
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin n_errors++; \
	$display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module cpu_fetch_and_word_transfer_bench
	import cfw_pkg::*;
;
	logic i_clk, i_rst, cyc, stb, we, ack, mrd, mwr, chc, la, cld;
	logic [7:0] adr;
	logic [31:0] wdat, rdat, seed;
	logic [0:71] mrdata;
	logic [14:0] maddr, chaddr;
	cfw_word_t mwdata, chbus;
	cfw_strobe_t mstb;
	int n_errors, checks_done;
	logic [9:0] ops [0:12] = '{`CFW_OP_STO, `CFW_OP_SLW, `CFW_OP_STQ, `CFW_OP_STZ, `CFW_OP_STP,
		`CFW_OP_STD, `CFW_OP_STT, `CFW_OP_STA, `CFW_OP_SLQ, `CFW_OP_STL, `CFW_OP_LDQ, `CFW_OP_XCA, `CFW_OP_XCL};
	cfw_core DUT (.i_clk(i_clk), .i_rst(i_rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
		.i_wb_dat(wdat), .i_wb_sel(4'hf), .o_wb_dat(rdat), .o_wb_ack(ack), .i_mem_rdata(mrdata), .o_mem_rd(mrd),
		.o_mem_wr(mwr), .o_mem_addr(maddr), .o_mem_wdata(mwdata), .o_mem_strobe(mstb), .i_chan_cycle(chc),
		.i_chan_addr(chaddr), .i_chan_load_op(cld), .i_lookahead(la), .o_chan_bus(chbus));
	cfw_mem_model mem_m (.i_clk(i_clk), .i_rd(mrd), .i_wr(mwr), .i_addr(maddr), .i_wdata(mwdata),
		.i_strobe(mstb), .o_rdata(mrdata));
	initial begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end
	function automatic logic [31:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction : rnd
	// ==========================================
	// bus cycles, entered just after a rising edge
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge i_clk);
			n++;
		end while (ack !== 1'b1 && n < 40);
		if (n >= 40) n_errors++;
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge i_clk);
	endtask : wb
	task automatic get36(input logic [7:0] lo, input logic [7:0] hi, output logic [0:37] v);
		logic [31:0] a, b;
		wb(1'b0, lo, 32'h0, a);
		wb(1'b0, hi, 32'h0, b);
		v = {b[5:0], a};
	endtask : get36
	task automatic run(input logic [9:0] op, input logic ind);
		cfw_word_t sw, qw, old, iw, ex, xs, xq;
		logic [0:37] g;
		logic [31:0] r;
		logic [14:0] x, tgt;
		logic sq, sp;
		int n;
		r = rnd();
		sw = {r[3:0], rnd()};
		qw = {r[7:4], rnd()};
		old = {r[11:8], rnd()};
		iw = {r[15:12], rnd()};
		{sq, sp} = r[17:16];
		x = {12'h001, r[20:18]};
		tgt = ind ? {12'h003, r[23:21]} : x;
		iw[0] = op[9];
		iw[1:2] = 2'b00;
		iw[3:11] = op[8:0];
		iw[12:13] = {ind, ind};
		iw[14:20] = 7'h0;
		iw[21:35] = x;
		mem_m.cells[2] = iw;
		mem_m.cells[x[4:0]] = ind ? {r[26:24], rnd(), 1'b0} : old;
		if (ind) begin
			mem_m.cells[x[4:0]][21:35] = tgt;
			mem_m.cells[tgt[4:0]] = old;
		end
		wb(1'b1, `CFW_ACL, sw[4:35], r);
		wb(1'b1, `CFW_ACH, {26'h0, sq, sp, sw[0:3]}, r);
		wb(1'b1, `CFW_MQL, qw[4:35], r);
		wb(1'b1, `CFW_MQH, {28'h0, qw[0:3]}, r);
		wb(1'b1, `CFW_PC, 32'h2, r);
		wb(1'b1, `CFW_CTRL, 32'h1, r);
		wb(1'b1, `CFW_CTRL, 32'h2, r);
		n = 0;
		do begin
			wb(1'b0, `CFW_STATUS, 32'h0, r);
			n++;
		end while (r[4:0] !== 5'h02 && n < 40);
		`CHK("back to idle", 5'h02, r[4:0])
		ex = old;
		xs = sw;
		xq = qw;
		case (op)
			`CFW_OP_STO: ex = sw;
			`CFW_OP_SLW: ex = {sp, sw[1:35]};
			`CFW_OP_STQ: ex = qw;
			`CFW_OP_STZ: ex = '0;
			`CFW_OP_STP: ex[0:2] = {sp, sw[1:2]};
			`CFW_OP_STD: ex[3:17] = sw[3:17];
			`CFW_OP_STT: ex[18:20] = sw[18:20];
			`CFW_OP_STA: ex[21:35] = sw[21:35];
			`CFW_OP_SLQ: ex[0:17] = qw[0:17];
			`CFW_OP_STL: ex[21:35] = 15'h3;
			`CFW_OP_LDQ: xq = old;
			`CFW_OP_XCA: {sq, sp, xs, xq} = {2'b00, qw, sw};
			`CFW_OP_XCL: {sq, sp, xs, xq} = {1'b0, qw[0], 1'b0, qw[1:35], sp, sw[1:35]};
			default: ex = old;
		endcase
		`CHK("stored word", ex, mem_m.cells[tgt[4:0]])
		get36(`CFW_ACL, `CFW_ACH, g);
		`CHK("sum register", {sq, sp, xs}, g)
		get36(`CFW_MQL, `CFW_MQH, g);
		`CHK("quotient register", xq, g[2:37])
		wb(1'b0, `CFW_PC, 32'h0, r);
		`CHK("next location", 32'h3, r)
		wb(1'b0, `CFW_IR, 32'h0, r);
		`CHK("opcode holder", {22'h0, op}, r)
	endtask : run
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : tally_and_finish
	// ==========================================
	// main sequence
	initial begin
		logic [31:0] r;
		{cyc, stb, we, chc, la, cld, adr, wdat, chaddr} = '0;
		i_rst = 1'b1;
		seed = 32'h94d2;
		n_errors = 0;
		checks_done = 0;
		repeat (2) @(posedge i_clk);
		i_rst <= 1'b0;
		@(posedge i_clk);
		wb(1'b0, `CFW_STATUS, 32'h0, r);
		`CHK("status at reset", 32'h2, r)
		wb(1'b0, 8'h40, 32'h0, r);
		`CHK("unmapped read", 32'h0, r)
		r = rnd();
		chaddr <= r[14:0];
		chc <= 1'b1;
		repeat (3) @(posedge i_clk);
		`CHK("channel address", r[14:0], maddr)
		`CHK("channel bus open", 36'hfffffffff, chbus)
		chc <= 1'b0;
		la <= 1'b1;
		repeat (3) @(posedge i_clk);
		`CHK("look-ahead address", 15'h7fff, maddr)
		la <= 1'b0;
		cld <= 1'b1;
		repeat (2) @(posedge i_clk);
		`CHK("channel bus idle", 36'h0, chbus)
		cld <= 1'b0;
		@(posedge i_clk);
		for (int i = 0; i < 13; i++) run(ops[i], 1'b0);
		run(`CFW_OP_STO, 1'b1);
		`CHK("channel bus quiet", 36'h0, chbus)
		tally_and_finish();
	end
	initial begin
		#100000;
		n_errors++;
		tally_and_finish();
	end
endmodule : cpu_fetch_and_word_transfer_bench
